// *** core/amc_pkg.sv ***
// What this block does
// - Take two-to-the-N samples, N from config bits 5:3.
// - Channel select field bits 2:0 picks input.
// - Average result register holds mean of samples.
// - Minimum result register holds lowest sample.
// - Maximum result register holds highest sample.
// - Registers reached via I2C target 0x50/0x51.
// - Launch bit self-clears when conversion finishes.
package amc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR      = 7'h28;
    localparam logic [7:0] REG_ENABLE    = 8'h50;
    localparam logic [7:0] REG_CONFIG    = 8'h51;
    localparam logic [7:0] REG_AVG       = 8'h53;
    localparam logic [7:0] REG_MIN       = 8'h54;
    localparam logic [7:0] REG_MAX       = 8'h55;
    localparam int         GO_BIT        = 0;
    localparam int         EXP_LSB       = 3;
    localparam int         EXP_MSB       = 5;
    localparam int         CHAN_LSB      = 0;
    localparam int         CHAN_MSB      = 2;
    localparam logic [5:0] CONFIG_RESET  = 6'h00;
    localparam logic [7:0] RESULT_RESET  = 8'h00;
    localparam logic [7:0] MIN_INIT      = 8'hFF;
    localparam logic [7:0] MAX_INIT      = 8'h00;

    // ------------------------------------------------------------
    // Channel codes
    // ------------------------------------------------------------
    localparam logic [2:0] CHAN_HAPTIC   = 3'h0;
    localparam logic [2:0] CHAN_MONITOR  = 3'h1;
    localparam logic [2:0] CHAN_CHARGER  = 3'h3;
    localparam logic [2:0] CHAN_SAFE     = 3'h4;
    localparam logic [2:0] CHAN_BOOST    = 3'h5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        BUS_IDLE = 6'h01,
        BUS_ADDR = 6'h02,
        BUS_SACK = 6'h04,
        BUS_RX   = 6'h08,
        BUS_TX   = 6'h10,
        BUS_MACK = 6'h20
    } amc_bus_state_t;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'h1,
        CONV_BUSY = 2'h2
    } amc_conv_state_t;

    typedef struct packed {
        amc_bus_state_t bst;
        logic           scl_q;
        logic           sda_q;
        logic [3:0]     bit_cnt;
        logic [7:0]     shift;
        logic [7:0]     ptr;
        logic           rw;
        logic           have_ptr;
        logic           nack;
        logic           sda_oe;
    } amc_i2c_t;

    typedef struct packed {
        amc_conv_state_t cst;
        logic            go;
        logic [5:0]      cfg;
        logic [2:0]      exp;
        logic [6:0]      cnt;
        logic [14:0]     sum;
        logic [7:0]      lo;
        logic [7:0]      hi;
        logic [7:0]      avg;
        logic [7:0]      min;
        logic [7:0]      max;
        logic            req;
    } amc_conv_t;

    typedef struct packed {
        amc_i2c_t  i2c;
        amc_conv_t conv;
    } amc_state_t;

endpackage

// *** core/amc_adc_ctrl.sv ***
`timescale 1ns/1ns
module amc_adc_ctrl #(
    parameter int SAMPLE_W = 8
) (
    // Clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                srst_in,
    // I2C target pins
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_out,
    // Converter side
    output logic [2:0]               input_channel_select_out,
    output logic                     sample_req_out,
    input  wire logic                sample_valid_in,
    input  wire logic [SAMPLE_W-1:0] sample_data_in,
    output logic                     conversion_busy_out
);

    // ------------------------------------------------------------
    // Checks and helpers
    // ------------------------------------------------------------
    if (SAMPLE_W != 8) begin : g_bad_width
        $error("SAMPLE_W must be 8 to match the result registers");
    end

    function automatic logic [6:0] last_index(input logic [2:0] e);
        last_index = 7'((8'h01 << e) - 8'h01);
    endfunction

    amc_pkg::amc_state_t s;
    amc_pkg::amc_state_t next_s;
    logic                wr_stb;
    logic [7:0]          wr_addr;
    logic [7:0]          wr_data;

    function automatic logic [7:0] read_reg(input amc_pkg::amc_conv_t c, input logic [7:0] a);
        case (a)
            amc_pkg::REG_ENABLE: read_reg = {7'h00, c.go};
            amc_pkg::REG_CONFIG: read_reg = {2'h0, c.cfg};
            amc_pkg::REG_AVG:    read_reg = c.avg;
            amc_pkg::REG_MIN:    read_reg = c.min;
            amc_pkg::REG_MAX:    read_reg = c.max;
            default:             read_reg = 8'h00;
        endcase
    endfunction

    wire scl_rise = scl_in & ~s.i2c.scl_q;
    wire scl_fall = ~scl_in & s.i2c.scl_q;
    wire bus_start = scl_in & s.i2c.scl_q & s.i2c.sda_q & ~sda_in;
    wire bus_stop = scl_in & s.i2c.scl_q & ~s.i2c.sda_q & sda_in;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [14:0] nsum;
        logic [7:0]  nlo;
        logic [7:0]  nhi;
        logic [7:0]  rd;
        nsum = 15'h0000;
        nlo = 8'h00;
        nhi = 8'h00;
        rd = 8'h00;
        next_s = s;
        next_s.conv.req = 1'b0;
        next_s.i2c.scl_q = scl_in;
        next_s.i2c.sda_q = sda_in;
        wr_stb = 1'b0;
        wr_addr = s.i2c.ptr;
        wr_data = s.i2c.shift;

        // The I2C target: samples on SCL rise, changes SDA on SCL fall.
        if (bus_start) begin
            next_s.i2c.bst = amc_pkg::BUS_ADDR;
            next_s.i2c.bit_cnt = 4'h0;
            next_s.i2c.have_ptr = 1'b0;
            next_s.i2c.sda_oe = 1'b0;
        end else if (bus_stop) begin
            next_s.i2c.bst = amc_pkg::BUS_IDLE;
            next_s.i2c.sda_oe = 1'b0;
        end else begin
            case (s.i2c.bst)
                amc_pkg::BUS_IDLE: begin
                    next_s.i2c.sda_oe = 1'b0;
                end
                amc_pkg::BUS_ADDR, amc_pkg::BUS_RX: begin
                    if (scl_rise) begin
                        next_s.i2c.shift = {s.i2c.shift[6:0], sda_in};
                        next_s.i2c.bit_cnt = 4'(s.i2c.bit_cnt + 4'h1);
                    end else if (scl_fall && s.i2c.bit_cnt == 4'h8) begin
                        next_s.i2c.bit_cnt = 4'h0;
                        next_s.i2c.bst = amc_pkg::BUS_SACK;
                        next_s.i2c.sda_oe = 1'b1;
                        if (s.i2c.bst == amc_pkg::BUS_ADDR) begin
                            next_s.i2c.rw = s.i2c.shift[0];
                            if (s.i2c.shift[7:1] != amc_pkg::DEV_ADDR) begin
                                next_s.i2c.bst = amc_pkg::BUS_IDLE;
                                next_s.i2c.sda_oe = 1'b0;
                            end
                        end else if (!s.i2c.have_ptr) begin
                            next_s.i2c.ptr = s.i2c.shift;
                            next_s.i2c.have_ptr = 1'b1;
                        end else begin
                            wr_stb = 1'b1;
                            next_s.i2c.ptr = 8'(s.i2c.ptr + 8'h01);
                        end
                    end
                end
                amc_pkg::BUS_SACK: begin
                    if (scl_fall) begin
                        next_s.i2c.sda_oe = 1'b0;
                        next_s.i2c.bst = amc_pkg::BUS_RX;
                        if (s.i2c.rw) begin
                            rd = read_reg(s.conv, s.i2c.ptr);
                            next_s.i2c.shift = rd;
                            next_s.i2c.ptr = 8'(s.i2c.ptr + 8'h01);
                            next_s.i2c.sda_oe = ~rd[7];
                            next_s.i2c.bst = amc_pkg::BUS_TX;
                        end
                    end
                end
                amc_pkg::BUS_TX: begin
                    if (scl_fall) begin
                        next_s.i2c.shift = {s.i2c.shift[6:0], 1'b0};
                        next_s.i2c.bit_cnt = 4'(s.i2c.bit_cnt + 4'h1);
                        next_s.i2c.sda_oe = ~s.i2c.shift[6];
                        if (s.i2c.bit_cnt == 4'h7) begin
                            next_s.i2c.sda_oe = 1'b0;
                            next_s.i2c.bst = amc_pkg::BUS_MACK;
                        end
                    end
                end
                amc_pkg::BUS_MACK: begin
                    if (scl_rise) begin
                        next_s.i2c.nack = sda_in;
                    end else if (scl_fall) begin
                        next_s.i2c.bit_cnt = 4'h0;
                        if (s.i2c.nack) begin
                            next_s.i2c.bst = amc_pkg::BUS_IDLE;
                        end else begin
                            rd = read_reg(s.conv, s.i2c.ptr);
                            next_s.i2c.shift = rd;
                            next_s.i2c.ptr = 8'(s.i2c.ptr + 8'h01);
                            next_s.i2c.sda_oe = ~rd[7];
                            next_s.i2c.bst = amc_pkg::BUS_TX;
                        end
                    end
                end
                default: begin
                    next_s.i2c.bst = amc_pkg::BUS_IDLE;
                    next_s.i2c.sda_oe = 1'b0;
                end
            endcase
        end

        // Config may be rewritten mid-run; the exponent is latched at launch so the count holds.
        if (wr_stb && wr_addr == amc_pkg::REG_CONFIG) begin
            next_s.conv.cfg = wr_data[5:0];
        end
        case (s.conv.cst)
            amc_pkg::CONV_IDLE: begin
                if (wr_stb && wr_addr == amc_pkg::REG_ENABLE && wr_data[amc_pkg::GO_BIT]) begin
                    next_s.conv.go = 1'b1;
                    next_s.conv.exp = s.conv.cfg[amc_pkg::EXP_MSB:amc_pkg::EXP_LSB];
                    next_s.conv.cnt = 7'h00;
                    next_s.conv.sum = 15'h0000;
                    next_s.conv.lo = amc_pkg::MIN_INIT;
                    next_s.conv.hi = amc_pkg::MAX_INIT;
                    next_s.conv.req = 1'b1;
                    next_s.conv.cst = amc_pkg::CONV_BUSY;
                end
            end
            amc_pkg::CONV_BUSY: begin
                if (sample_valid_in) begin
                    nsum = 15'(s.conv.sum + {7'h00, sample_data_in});
                    nlo = (sample_data_in < s.conv.lo) ? sample_data_in : s.conv.lo;
                    nhi = (sample_data_in > s.conv.hi) ? sample_data_in : s.conv.hi;
                    next_s.conv.sum = nsum;
                    next_s.conv.lo = nlo;
                    next_s.conv.hi = nhi;
                    if (s.conv.cnt == last_index(s.conv.exp)) begin
                        next_s.conv.avg = 8'(nsum >> s.conv.exp);
                        next_s.conv.min = nlo;
                        next_s.conv.max = nhi;
                        next_s.conv.go = 1'b0;
                        next_s.conv.cst = amc_pkg::CONV_IDLE;
                    end else begin
                        next_s.conv.cnt = 7'(s.conv.cnt + 7'h01);
                        next_s.conv.req = 1'b1;
                    end
                end
            end
            default: begin
                next_s.conv.cst = amc_pkg::CONV_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            s <= '0;
            s.i2c.bst <= amc_pkg::BUS_IDLE;
            s.i2c.scl_q <= 1'b1;
            s.i2c.sda_q <= 1'b1;
            s.conv.cst <= amc_pkg::CONV_IDLE;
            s.conv.cfg <= amc_pkg::CONFIG_RESET;
            s.conv.avg <= amc_pkg::RESULT_RESET;
            s.conv.min <= amc_pkg::RESULT_RESET;
            s.conv.max <= amc_pkg::RESULT_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = s.i2c.sda_oe;
    assign input_channel_select_out = s.conv.cfg[amc_pkg::CHAN_MSB:amc_pkg::CHAN_LSB];
    assign sample_req_out = s.conv.req;
    assign conversion_busy_out = s.conv.go;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_go_self_clear: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.conv.cst == amc_pkg::CONV_BUSY && sample_valid_in && s.conv.cnt == last_index(s.conv.exp)
        |=> !s.conv.go && s.conv.cst == amc_pkg::CONV_IDLE) else $error("launch bit did not clear");
    a_launch_resets: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.conv.cst == amc_pkg::CONV_BUSY && $rose(s.conv.go)
        |-> s.conv.sum == 15'h0000 && s.conv.lo == 8'hFF && s.conv.hi == 8'h00 && sample_req_out)
        else $error("trackers not reset at launch");
    a_min_tracker: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.conv.cst == amc_pkg::CONV_BUSY && sample_valid_in |=> s.conv.lo <= $past(sample_data_in))
        else $error("minimum tracker above a sample");
    a_max_tracker: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.conv.cst == amc_pkg::CONV_BUSY && sample_valid_in |=> s.conv.hi >= $past(sample_data_in))
        else $error("maximum tracker below a sample");
    a_avg_bounded: assert property (@(posedge core_clk_in) disable iff (srst_in)
        $fell(s.conv.go) |-> s.conv.min <= s.conv.avg && s.conv.avg <= s.conv.max)
        else $error("average outside min and max");
    a_single_sample: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.conv.cst == amc_pkg::CONV_BUSY && s.conv.exp == 3'h0 && sample_valid_in
        |=> s.conv.avg == $past(sample_data_in) && s.conv.max == $past(sample_data_in) && !s.conv.go)
        else $error("single sample result wrong");
    a_results_steady: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.conv.go && $past(s.conv.go) |-> $stable(s.conv.avg) && $stable(s.conv.min) && $stable(s.conv.max))
        else $error("results changed mid conversion");
    a_addr_ack: assert property (@(posedge core_clk_in) disable iff (srst_in)
        s.i2c.bst == amc_pkg::BUS_ADDR && scl_fall && s.i2c.bit_cnt == 4'h8 && !bus_start && !bus_stop
        |=> sda_oe_out == ($past(s.i2c.shift[7:1]) == amc_pkg::DEV_ADDR))
        else $error("address acknowledge wrong");
    a_channel_out: assert property (@(posedge core_clk_in) disable iff (srst_in)
        wr_stb && wr_addr == amc_pkg::REG_CONFIG |=> input_channel_select_out == $past(wr_data[2:0]))
        else $error("channel select not routed");

endmodule

// *** verif/amc_conv_model.sv ***
`timescale 1ns/1ns
module amc_conv_model (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       srst_in,
    // Request and pacing
    input  wire logic       sample_req_in,
    input  wire logic [3:0] delay_in,
    input  wire logic [7:0] value_in,
    // Answer
    output logic            sample_valid_out,
    output logic [7:0]      sample_data_out
);
    logic [3:0] wait_cnt;
    logic       pending;

    // --------------------------------------------
    // Converter answer
    // --------------------------------------------
    // Between answers the data lines toggle, so a stale sample never passes for a fresh one.
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pending          <= 1'b0;
            wait_cnt         <= 4'h0;
            sample_valid_out <= 1'b0;
            sample_data_out  <= 8'h00;
        end else begin
            sample_valid_out <= 1'b0;
            sample_data_out  <= ~sample_data_out;
            if (sample_req_in) begin
                pending  <= 1'b1;
                wait_cnt <= delay_in;
            end else if (pending && wait_cnt == 4'h0) begin
                pending          <= 1'b0;
                sample_valid_out <= 1'b1;
                sample_data_out  <= value_in;
            end else if (pending) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule

// *** verif/test_adc_average_min_max_control.sv ***
`timescale 1ns/1ns
module test_adc_average_min_max_control;
    logic       core_clk_in;
    logic       srst_in;
    logic       scl;
    logic       sda_drv;
    wire        sda_line;
    logic       sda_out;
    logic       sda_oe_out;
    logic [2:0] chan;
    logic       req;
    logic       valid;
    logic [7:0] sdata;
    logic       busy;
    logic [3:0] delay;
    logic [7:0] value;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] r;
    logic [7:0] d;
    int         seed;
    int         err_count;
    int         checks_done;
    int         cycles;
    int         reqs;
    int         got_n;
    int         sum;

    // The target only pulls the wire low; the line is high unless the host or the target pulls it low.
    assign sda_line = sda_drv & ~(sda_oe_out & ~sda_out);

    amc_adc_ctrl #(.SAMPLE_W(8)) dut (
        .core_clk_in              (core_clk_in),
        .srst_in                  (srst_in),
        .scl_in                   (scl),
        .sda_in                   (sda_line),
        .sda_out                  (sda_out),
        .sda_oe_out               (sda_oe_out),
        .input_channel_select_out (chan),
        .sample_req_out           (req),
        .sample_valid_in          (valid),
        .sample_data_in           (sdata),
        .conversion_busy_out      (busy)
    );

    amc_conv_model conv (
        .core_clk_in      (core_clk_in),
        .srst_in          (srst_in),
        .sample_req_in    (req),
        .delay_in         (delay),
        .value_in         (value),
        .sample_valid_out (valid),
        .sample_data_out  (sdata)
    );

    always #25 core_clk_in = ~core_clk_in;

    // --------------------------------------------
    // Expected results and hang guard
    // --------------------------------------------
    always @(posedge core_clk_in) begin
        cycles++;
        if (req === 1'b1) reqs++;
        if (valid === 1'b1 && busy === 1'b1) begin
            got_n++;
            sum = sum + sdata;
            if (sdata < lo) lo = sdata;
            if (sdata > hi) hi = sdata;
            value <= 8'($random(seed));
        end
        if (cycles == 90000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // --------------------------------------------
    // Two-wire host
    // --------------------------------------------
    task automatic half();
        repeat (4) @(posedge core_clk_in);
    endtask

    // One bit: data is set while the clock is low and read while it is high.
    task automatic bit_cycle(output logic s);
        half();
        scl <= 1'b1;
        half();
        s = sda_line;
        scl <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic start_cond();
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic stop_cond();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask

    task automatic send(input logic [7:0] b, input logic want);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_drv <= b[i];
            bit_cycle(s);
        end
        sda_drv <= 1'b1;
        bit_cycle(s);
        check("target_ack", {7'h00, ~s}, {7'h00, want});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        start_cond();
        send(8'h50, 1'b1);
        send(a, 1'b1);
        send(v, 1'b1);
        stop_cond();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        logic s;
        start_cond();
        send(8'h50, 1'b1);
        send(a, 1'b1);
        start_cond();
        send(8'h51, 1'b1);
        sda_drv <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(v[i]);
        end
        bit_cycle(s);
        stop_cond();
    endtask

    // Several bytes in one read: the host acknowledges each byte but the last.
    task automatic rd_burst(input logic [7:0] a, output logic [23:0] v);
        logic s;
        start_cond();
        send(8'h50, 1'b1);
        send(a, 1'b1);
        start_cond();
        send(8'h51, 1'b1);
        for (int i = 23; i >= 0; i--) begin
            sda_drv <= 1'b1;
            bit_cycle(v[i]);
            if (i % 8 == 0) begin
                sda_drv <= (i == 0);
                bit_cycle(s);
            end
        end
        stop_cond();
    endtask

    // --------------------------------------------
    // Conversion with result readback
    // --------------------------------------------
    task automatic run_conv(input logic [2:0] e);
        int          n;
        logic [23:0] res;
        delay <= (e == 3'h7) ? 4'hF : (e == 3'h0) ? 4'h0 : 4'($random(seed) & 7);
        // The monitor channel needs a ratio field outside this block, so conversions stay on the charger input.
        wr(8'h51, {2'b00, e, 3'h3});
        got_n = 0;
        sum = 0;
        lo = 8'hFF;
        hi = 8'h00;
        reqs = 0;
        wr(8'h50, 8'h01);
        if (e == 3'h7) begin
            check("busy_mid_run", {7'h00, busy}, 8'h01);
            wr(8'h50, 8'h00);
            rd(8'h50, r);
            check("launch_mid_run", r, 8'h01);
        end
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge core_clk_in);
            n++;
        end
        check("busy_cleared", {7'h00, busy}, 8'h00);
        check("sample_count", 8'(got_n), 8'(1 << e));
        check("request_count", 8'(reqs), 8'(1 << e));
        rd_burst(8'h53, res);
        check("average", res[23:16], 8'(sum >> e));
        check("minimum", res[15:8], lo);
        check("maximum", res[7:0], hi);
        rd(8'h50, r);
        check("launch_cleared", r, 8'h00);
        $display("test conversion size %0d done", e);
    endtask

    initial begin
        seed = 44;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        core_clk_in = 1'b0;
        srst_in = 1'b1;
        scl = 1'b1;
        sda_drv = 1'b1;
        delay = 4'h0;
        value = 8'($random(seed));
        repeat (5) @(posedge core_clk_in);
        srst_in <= 1'b0;
        @(posedge core_clk_in);
        for (int a = 8'h50; a <= 8'h55; a++) begin
            rd(8'(a), r);
            check("reset_value", r, 8'h00);
        end
        wr(8'h55, 8'hA5);
        rd(8'h55, r);
        check("read_only_write", r, 8'h00);
        start_cond();
        send(8'h52, 1'b0);
        stop_cond();
        $display("test reset and access done");
        for (int c = 0; c < 8; c++) begin
            d = {2'b00, 3'($random(seed)), 3'(c)};
            wr(8'h51, d);
            check("channel_out", {5'h00, chan}, {5'h00, 3'(c)});
            rd(8'h51, r);
            check("config_readback", r, d);
        end
        $display("test channel select done");
        for (int e = 0; e < 8; e++) begin
            run_conv(3'(e));
        end
        wrap_up();
    end
endmodule
